/* File: core/hrw_core.sv */
/*
  Hibernation seconds counter with its write-crossing interface.
  Holds the control, counter, match, load, trim and retained-data
  registers, an AHB-Lite slave and the oscillator-driven tick.
  Assumes the oscillator pins are asynchronous to clk_i and that
  the AHB master shares clk_i.
*/
// Added by the designer: the AHB-Lite register port and the address map.
// Function
// R1: slow writes cross on oscillator edge, set flag
// R2: software verifies slow writes by reading back
// R3: write-complete flag ignores software writes
// R4: software polls flag before control writes
// R5: software uses read-modify-write on control
// R6: write meeting a tick is flagged hazard
// R7: software avoids writes on tick boundaries
// R8: software programs everything before enabling counter
// R9: match interrupt serviced within one second
// R10: one-shot timer bounds the safe window
// R11: software never selects supply-kept hibernate mode
// R12: clock source is crystal or external oscillator
// R13: counter ticks each second, match pulses
`timescale 1ns/1ps
module hrw_core
  import hrw_pkg::*;
#(
  parameter int unsigned XTAL_EDGES = XTAL_DIV, // Crystal edges per tick
  parameter int unsigned EXT_EDGES = EXT_DIV // External edges per tick
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic xtal_clk_i, // Crystal oscillator output
  input wire logic ext_osc_i, // External oscillator
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic match_o // One-cycle pulse on a match
);

  // Whole module state
  typedef struct packed {
    logic en;
    logic sel; // 0 crystal, 1 external oscillator
    logic vkeep; // Supply-kept hibernate mode select
    logic write_complete_flag; // Write-complete flag
    hrw_pend_type pend;
    logic [31:0] cnt;
    logic [31:0] m0;
    logic [31:0] m1;
    logic [31:0] ld;
    logic [31:0] trim;
    logic [DATA_WORDS-1:0][31:0] mem;
    logic [PRESC_W-1:0] presc;
    logic match_flag;
    logic haz_flag;
    logic match_pulse;
    logic [2:0] xs; // Crystal synchroniser and edge stage
    logic [2:0] es; // External synchroniser and edge stage
    hrw_xfer_type ap;
    logic rd_stage;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } hrw_state_type;

  hrw_state_type st_r;
  hrw_state_type st_nxt;

  // Decode a slow-domain register address
  function automatic logic slow_hit(input logic [7:0] a);
    slow_hit = (a == OFF_CNT) || (a == OFF_MATCH0) || (a == OFF_MATCH1) ||
               (a == OFF_LOAD) || (a == OFF_TRIM) || (a[7:6] == OFF_DATA[7:6]);
  endfunction : slow_hit

  // Combinational helpers
  logic osc_edge; // Edge of the selected oscillator
  logic tick; // One-second step
  logic apply; // Pending write lands now
  logic [PRESC_W-1:0] last_cnt; // Terminal prescaler value
  logic accept; // Address phase taken
  logic [31:0] cnt_next;

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Two-flop synchronisers, third stage for edge detect only
    st_nxt.xs = {st_r.xs[1:0], xtal_clk_i};
    st_nxt.es = {st_r.es[1:0], ext_osc_i};
    // Source select and tick generation
    osc_edge = st_r.sel ? (st_r.es[1] & ~st_r.es[2]) : (st_r.xs[1] & ~st_r.xs[2]); // R12
    last_cnt = st_r.sel ? PRESC_W'(EXT_EDGES - 1) : PRESC_W'(XTAL_EDGES - 1); // R12
    tick = st_r.en && osc_edge && (st_r.presc >= last_cnt); // R13
    apply = st_r.pend.busy && osc_edge; // R1
    if (!st_r.en) begin
      st_nxt.presc = '0;
    end else if (osc_edge) begin
      st_nxt.presc = tick ? '0 : st_r.presc + PRESC_W'(1);
    end
    // Counter step
    cnt_next = st_r.cnt + 32'h0000_0001; // R13
    st_nxt.match_pulse = 1'b0;
    if (tick) begin
      st_nxt.cnt = cnt_next;
      if (cnt_next == st_r.m0 || cnt_next == st_r.m1) begin
        st_nxt.match_flag = 1'b1; // R13
        st_nxt.match_pulse = 1'b1; // R13
      end
    end
    // Pending slow write lands on the oscillator edge
    if (apply) begin
      st_nxt.pend.busy = 1'b0;
      st_nxt.write_complete_flag = 1'b1; // R1
      if (tick) begin
        st_nxt.haz_flag = 1'b1; // R6
      end
      case (st_r.pend.addr)
        OFF_CNT: begin
          st_nxt.cnt = st_r.pend.data; // R6
        end
        OFF_LOAD: begin
          st_nxt.ld = st_r.pend.data;
          st_nxt.cnt = st_r.pend.data;
        end
        OFF_MATCH0: begin
          st_nxt.m0 = st_r.pend.data;
        end
        OFF_MATCH1: begin
          st_nxt.m1 = st_r.pend.data;
        end
        OFF_TRIM: begin
          st_nxt.trim = st_r.pend.data;
        end
        default: begin
          // Retained data word
          st_nxt.mem[st_r.pend.addr[DATA_IW+1:2]] = st_r.pend.data;
        end
      endcase
    end
    // Bus address phase, captured only while the bus is ready
    accept = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);
    if (hready_i) begin
      st_nxt.ap.valid = accept;
      st_nxt.ap.write = hwrite_i;
      st_nxt.ap.addr = haddr_i[7:0];
    end
    st_nxt.resp = RESP_OKAY;
    // A read taken now holds ready low through its first data cycle,
    // so the master never samples a stale word
    st_nxt.ready = !(accept && !hwrite_i);
    st_nxt.rd_stage = accept && !hwrite_i;
    // Bus data phase, writes
    if (st_r.ap.valid && st_r.ap.write) begin
      case (st_r.ap.addr)
        OFF_CTL: begin // R3
          st_nxt.en = hwdata_i[CTL_EN_BIT];
          st_nxt.sel = hwdata_i[CTL_SEL_BIT];
          st_nxt.vkeep = hwdata_i[CTL_VKEEP_BIT];
          // Write-complete bit is not writable
        end
        OFF_STAT: begin
          // Write one to clear, a new event wins
          if (hwdata_i[STAT_MATCH_BIT] && !(tick && st_nxt.match_pulse)) begin
            st_nxt.match_flag = 1'b0;
          end
          if (hwdata_i[STAT_HAZ_BIT] && !(apply && tick)) begin
            st_nxt.haz_flag = 1'b0;
          end
        end
        default: begin
          // Slow register, taken only while no write is in flight
          if (slow_hit(st_r.ap.addr) && !st_r.pend.busy) begin
            st_nxt.pend.busy = 1'b1; // R1
            st_nxt.pend.addr = st_r.ap.addr;
            st_nxt.pend.data = hwdata_i;
            st_nxt.write_complete_flag = 1'b0; // R1
          end
        end
      endcase
    end
    // Bus data phase, reads: the wait cycle fetches the word
    if (st_r.rd_stage) begin
      st_nxt.ap.valid = 1'b0;
      case (st_r.ap.addr)
        OFF_CTL: begin
          st_nxt.rdata = RST_WORD;
          st_nxt.rdata[CTL_EN_BIT] = st_r.en;
          st_nxt.rdata[CTL_SEL_BIT] = st_r.sel;
          st_nxt.rdata[CTL_VKEEP_BIT] = st_r.vkeep;
          st_nxt.rdata[CTL_WRC_BIT] = st_r.write_complete_flag;
        end
        OFF_CNT: begin
          st_nxt.rdata = st_r.cnt;
        end
        OFF_MATCH0: begin
          st_nxt.rdata = st_r.m0;
        end
        OFF_MATCH1: begin
          st_nxt.rdata = st_r.m1;
        end
        OFF_LOAD: begin
          st_nxt.rdata = st_r.ld;
        end
        OFF_TRIM: begin
          st_nxt.rdata = st_r.trim;
        end
        OFF_STAT: begin
          st_nxt.rdata = RST_WORD;
          st_nxt.rdata[STAT_MATCH_BIT] = st_r.match_flag;
          st_nxt.rdata[STAT_HAZ_BIT] = st_r.haz_flag;
        end
        default: begin
          // Retained data or unmapped
          st_nxt.rdata = slow_hit(st_r.ap.addr) ? st_r.mem[st_r.ap.addr[DATA_IW+1:2]] : RST_WORD;
        end
      endcase
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.write_complete_flag <= RST_WRC;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign hrdata_o = st_r.rdata;
  assign hreadyout_o = st_r.ready;
  assign hresp_o = st_r.resp;
  assign match_o = st_r.match_pulse;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Slow write taken in a data phase
  sequence s_slow_take;
    st_r.ap.valid && st_r.ap.write && slow_hit(st_r.ap.addr) && !st_r.pend.busy;
  endsequence
  // Read address phase taken at this edge
  sequence s_rd_take;
    accept && !hwrite_i;
  endsequence
  // One wait cycle, then the word stands with ready
  sequence s_rd_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  // Slow write arriving while another is still in flight
  sequence s_slow_drop;
    st_r.ap.valid && st_r.ap.write && slow_hit(st_r.ap.addr) && st_r.pend.busy && !apply;
  endsequence

  AST_WRC_CLEAR: assert property (s_slow_take |=> !st_r.write_complete_flag && st_r.pend.busy) // R1
    else $error("flag not cleared by slow write");
  AST_WRC_SET: assert property (apply |=> st_r.write_complete_flag && !st_r.pend.busy) // R1
    else $error("flag not set after write landed");
  AST_WRC_RO: assert property (st_r.ap.valid && st_r.ap.write && st_r.ap.addr == OFF_CTL
      && !apply |=> st_r.write_complete_flag == $past(st_r.write_complete_flag)) // R3
    else $error("control write changed the flag");
  AST_HAZARD: assert property (apply && tick |=> st_r.haz_flag) // R6
    else $error("hazard not flagged");
  AST_TICK_STEP: assert property (tick && !apply |=> st_r.cnt == $past(st_r.cnt) + 32'h1) // R13
    else $error("counter did not step");
  AST_MATCH: assert property (tick && (cnt_next == st_r.m0) |=> match_o ##1 !match_o) // R13
    else $error("match pulse wrong");
  AST_NO_TICK_OFF: assert property (!st_r.en |-> !tick) // R13
    else $error("tick while disabled");
  AST_SRC: assert property (!osc_edge && st_r.en && st_nxt.en
      |=> st_r.presc == $past(st_r.presc)) // R12
    else $error("prescaler moved without oscillator edge");
  AST_READ_WAIT: assert property (s_rd_take |=> s_rd_wait)
    else $error("read wait state wrong");

  // Refusals, sticky flags and read data
  // A dropped write leaves the pending word and the flag alone
  AST_DROP: assert property (s_slow_drop
      |=> st_r.pend.busy && $stable(st_r.pend.data) && !st_r.write_complete_flag) // R1
    else $error("second slow write not dropped");
  // Hazard flag sticks until software clears it
  AST_HAZ_STICKY: assert property (st_r.haz_flag
      && !(st_r.ap.valid && st_r.ap.write && st_r.ap.addr == OFF_STAT)
      |=> st_r.haz_flag) // R6
    else $error("hazard flag lost");
  // A new match wins over a clear in the same cycle
  AST_MATCH_WINS: assert property (tick && st_nxt.match_pulse |=> st_r.match_flag) // R13
    else $error("match flag not set");
  // Read data stands until the next read fetches a word
  AST_RDATA_HOLD: assert property (!st_r.rd_stage |=> $stable(hrdata_o))
    else $error("read data changed outside a read");
  // A counter read returns the counter of the wait cycle
  AST_RD_CNT: assert property (st_r.rd_stage && st_r.ap.addr == OFF_CNT
      |=> hrdata_o == $past(st_r.cnt)) // R13
    else $error("counter read wrong");
  AST_OKAY: assert property (hresp_o == RESP_OKAY)
    else $error("non-OKAY response");

endmodule : hrw_core

/* File: core/hrw_pkg.sv */
/*
  Package for the hibernation seconds counter with its write interface:
  register offsets, field positions, reset values and tick constants.
  Assumes a single 20 MHz system clock and an AHB-Lite register bus.
*/
package hrw_pkg;
  // System clock
  localparam int unsigned SYS_CLK_HZ = 20000000;
  // Counter tick period in seconds
  localparam int unsigned TICK_PERIOD_S = 1;
  // Oscillator rates for the two clock sources
  localparam int unsigned XTAL_HZ = 4194304;
  localparam int unsigned EXT_OSC_HZ = 32768;
  // Oscillator edges per counter tick, one per source
  localparam int unsigned XTAL_DIV = XTAL_HZ * TICK_PERIOD_S;
  localparam int unsigned EXT_DIV = EXT_OSC_HZ * TICK_PERIOD_S;
  // Prescaler width, large enough for the crystal divider
  localparam int unsigned PRESC_W = 23;

  // Register byte offsets
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_MATCH0 = 8'h08;
  localparam logic [7:0] OFF_MATCH1 = 8'h0c;
  localparam logic [7:0] OFF_LOAD = 8'h10;
  localparam logic [7:0] OFF_TRIM = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_DATA = 8'h40;
  // Retained words and their index width
  localparam int unsigned DATA_WORDS = 16;
  localparam int unsigned DATA_IW = 4;

  // Control register bit positions
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_SEL_BIT = 1;
  localparam int unsigned CTL_VKEEP_BIT = 2;
  localparam int unsigned CTL_WRC_BIT = 3;
  // Status register bit positions
  localparam int unsigned STAT_MATCH_BIT = 0;
  localparam int unsigned STAT_HAZ_BIT = 1;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic RST_WRC = 1'b1;

  // AHB codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic RESP_OKAY = 1'b0;

  // Bus transfer held between address and data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } hrw_xfer_type;

  // Slow-domain write waiting for an oscillator edge
  typedef struct packed {
    logic busy;
    logic [7:0] addr;
    logic [31:0] data;
  } hrw_pend_type;
endpackage : hrw_pkg

/* File: testbench/hrw_testbench.sv */
/*
  Self-checking testbench for the hibernation seconds counter and its
  write-crossing interface, driven through AHB-Lite tasks.
  Assumes hrw_core with short tick parameters, one 20 MHz clock and
  oscillator pins toggled by the bench far slower than the clock.
*/
`timescale 1ns/1ps
module testbench;
  import hrw_pkg::*;
  logic clk_i; // System clock
  logic resetn_i; // Synchronous reset, active low
  logic hsel_i; // Slave select
  logic [31:0] haddr_i; // Bus address
  logic [1:0] htrans_i; // Transfer kind
  logic hwrite_i; // Write strobe
  logic [2:0] hsize_i; // Transfer size
  logic [31:0] hwdata_i; // Write data
  logic hready_i; // Bus ready, fed back from the slave
  logic xtal_clk_i; // Crystal oscillator stand-in
  logic ext_osc_i; // External oscillator stand-in
  logic [31:0] hrdata_o; // Read data
  logic hreadyout_o; // Slave ready
  logic hresp_o; // Slave response
  logic match_o; // Match pulse
  int err_total; // Mismatches
  int checks_done; // Comparisons made
  int match_seen; // Match pulses counted

  // The one slave drives the bus ready
  assign hready_i = hreadyout_o;

  // Device with four crystal edges and two external edges per tick
  hrw_core #(.XTAL_EDGES(4), .EXT_EDGES(2)) hrw_core_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .xtal_clk_i(xtal_clk_i), .ext_osc_i(ext_osc_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .match_o(match_o)
  );

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Count match pulses
  always @(posedge clk_i) begin
    if (match_o === 1'b1) begin
      match_seen++;
    end
  end

  // Compare and report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One single AHB transfer, waiting on ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans_i <= 2'h2;
    haddr_i <= {24'h000000, a};
    hwrite_i <= wr;
    hsize_i <= HSIZE_WORD;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    check("response", {31'h0, hresp_o}, {31'h0, RESP_OKAY});
  endtask : bus

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  // Register read compared with an expected word
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h00000000, v);
    check(name, v, exp);
  endtask : rd_chk

  // Control write: poll the flag, then read-modify-write the fields
  task automatic ctl_wr(input logic en, input logic sel);
    logic [31:0] v;
    v = 32'h00000000;
    while (v[CTL_WRC_BIT] !== 1'b1) begin
      bus(1'b0, OFF_CTL, 32'h00000000, v);
    end
    v[CTL_EN_BIT] = en;
    v[CTL_SEL_BIT] = sel;
    v[CTL_VKEEP_BIT] = 1'b0;
    bus(1'b1, OFF_CTL, v, v);
  endtask : ctl_wr

  // Whole oscillator periods on one source, each far slower than the clock
  task automatic osc(input logic ext, input int n);
    repeat (n) begin
      if (ext) ext_osc_i <= 1'b1;
      else xtal_clk_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      if (ext) ext_osc_i <= 1'b0;
      else xtal_clk_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : osc

  // Counts, verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    resetn_i = 1'b0;
    hsel_i = 1'b1;
    haddr_i = 32'h00000000;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = HSIZE_WORD;
    hwdata_i = 32'h00000000;
    xtal_clk_i = 1'b0;
    ext_osc_i = 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    // Reset values: only the write-complete flag set
    rd_chk("ctl reset", OFF_CTL, 32'h00000008);
    for (int i = 1; i < 8; i++) begin
      rd_chk("reset word", 8'(i * 4), RST_WORD);
    end
    rd_chk("data reset", OFF_DATA, RST_WORD);
    // Software cannot clear the flag
    wr(OFF_CTL, 32'h00000000);
    rd_chk("flag kept", OFF_CTL, 32'h00000008);
    // Slow write: flag drops, lands on an oscillator edge
    wr(OFF_CNT, 32'h00000000);
    rd_chk("flag low", OFF_CTL, 32'h00000000);
    osc(1'b0, 1);
    rd_chk("flag back", OFF_CTL, 32'h00000008);
    // Second write while one is pending is dropped
    wr(OFF_DATA, 32'h00000011);
    wr(OFF_DATA + 8'h04, 32'h00000022);
    osc(1'b0, 1);
    rd_chk("data0", OFF_DATA, 32'h00000011);
    rd_chk("data1 dropped", OFF_DATA + 8'h04, 32'h00000000);
    // External source selected: crystal edges do not land the write
    ctl_wr(1'b0, 1'b1);
    wr(OFF_MATCH1, 32'h00000055);
    osc(1'b0, 2);
    rd_chk("ext pending", OFF_CTL, 32'h00000002);
    osc(1'b1, 1);
    rd_chk("ext landed", OFF_CTL, 32'h0000000a);
    rd_chk("match1", OFF_MATCH1, 32'h00000055);
    ctl_wr(1'b0, 1'b0);
    // Counter runs one step per four crystal edges, match on two
    wr(OFF_MATCH0, 32'h00000002);
    osc(1'b0, 1);
    ctl_wr(1'b1, 1'b0);
    osc(1'b0, 8);
    rd_chk("count", OFF_CNT, 32'h00000002);
    check("match pulses", 32'(match_seen), 32'h00000001);
    rd_chk("match sticky", OFF_STAT, 32'h00000001);
    wr(OFF_STAT, 32'h00000001);
    rd_chk("status clear", OFF_STAT, 32'h00000000);
    // A data write before each edge of a tick period meets one step
    for (int i = 0; i < 4; i++) begin
      wr(OFF_DATA + 8'h08, 32'(i));
      osc(1'b0, 1);
    end
    rd_chk("hazard", OFF_STAT, 32'h00000002);
    rd_chk("count after", OFF_CNT, 32'h00000003);
    rd_chk("data2", OFF_DATA + 8'h08, 32'h00000003);
    // Writes right after a step stay clear of the next boundary
    wr(OFF_STAT, 32'h00000003);
    wr(OFF_MATCH0, 32'h00000004);
    osc(1'b0, 4);
    check("match at four", 32'(match_seen), 32'h00000002);
    // Match window: new match value, then a data word, within one period
    wr(OFF_MATCH0, 32'h00000005);
    osc(1'b0, 1);
    wr(OFF_DATA + 8'h0c, 32'h0000005a);
    osc(1'b0, 1);
    rd_chk("window clean", OFF_STAT, 32'h00000001);
    osc(1'b0, 2);
    check("match at five", 32'(match_seen), 32'h00000003);
    rd_chk("data3", OFF_DATA + 8'h0c, 32'h0000005a);
    rd_chk("count five", OFF_CNT, 32'h00000005);
    // Trim and load cross like the rest; load also sets the counter
    wr(OFF_TRIM, 32'h00000007);
    osc(1'b0, 1);
    rd_chk("trim", OFF_TRIM, 32'h00000007);
    wr(OFF_LOAD, 32'h00000020);
    osc(1'b0, 1);
    rd_chk("load", OFF_LOAD, 32'h00000020);
    rd_chk("loaded count", OFF_CNT, 32'h00000020);
    test_done();
  end
endmodule : testbench
